// File: include/fds_pkg.sv
package fds_pkg;

  localparam int          FDS_NCH          = 4;      // Transducer channels
  // Parameter identifiers (register offsets)
  localparam logic [7:0]  FDS_ID_BLK_STATE = 8'h0F;  // Block state command
  localparam logic [7:0]  FDS_ID_DEV_STATE = 8'h19;  // Device state code
  localparam logic [7:0]  FDS_ID_SUMMARY   = 8'h1A;  // exception_summary
  localparam logic [7:0]  FDS_ID_LOCK      = 8'hCB;  // keypad_lock
  localparam logic [7:0]  FDS_ID_VALIDITY  = 8'hCC;  // channel_validity
  localparam logic [7:0]  FDS_ID_RESET     = 8'hCD;  // alarm_reset_command

  // Summary bit positions
  localparam int          FDS_SB_COM_ALM   = 0;      // Device-common alarm
  localparam int          FDS_SB_DEV_ALM   = 1;      // Device-specific alarm
  localparam int          FDS_SB_MFR_ALM   = 2;      // Maker-specific alarm
  localparam int          FDS_SB_UNUSED    = 3;      // No group assigned
  localparam int          FDS_SB_COM_WRN   = 4;      // Device-common warning
  localparam int          FDS_SB_DEV_WRN   = 5;      // Device-specific warning
  localparam int          FDS_SB_MFR_WRN   = 6;      // Maker-specific warning
  localparam int          FDS_SB_EXT_FMT   = 7;      // Extended format marker
  localparam logic [7:0]  FDS_DETAIL0_MASK = 8'h3D;  // Detail 0 bits 0,2,3,4,5

  // Validity nibble layout
  localparam int          FDS_NIB_W        = 4;      // Bits per channel
  localparam logic [3:0]  FDS_NIB_MASK     = 4'h7;   // Invalid, over, under kept

  // Reset command bits
  localparam int          FDS_RB_PSU_ALM   = 0;      // Power supply alarms
  localparam int          FDS_RB_PSU_WRN   = 1;      // Power supply warnings
  localparam int          FDS_RB_HC_ALM    = 2;      // Hot cathode supply alarms
  localparam int          FDS_RB_HC_WRN    = 3;      // Hot cathode supply warnings
  localparam int          FDS_RB_ALL_ALM   = 4;      // All alarms, supplies on
  localparam int          FDS_RB_ERR_FLAG  = 5;      // Error flag
  localparam int          FDS_RB_ALL       = 7;      // All flags plus buffer

  // Keypad lock codes
  localparam logic [7:0]  FDS_LOCK_OFF     = 8'h00;  // No lock
  localparam logic [7:0]  FDS_LOCK_PARA    = 8'h01;  // Parameter lock
  localparam logic [7:0]  FDS_LOCK_BUS     = 8'h02;  // Bus lock
  localparam logic [7:0]  FDS_LOCK_FULL    = 8'h03;  // Full lock

  // Device state codes
  localparam logic [7:0]  FDS_CODE_INIT    = 8'h64;  // 100
  localparam logic [7:0]  FDS_CODE_SELF    = 8'h01;  // Self testing
  localparam logic [7:0]  FDS_CODE_IDLE    = 8'h02;  // Idle
  localparam logic [7:0]  FDS_CODE_STFAULT = 8'h03;  // Self-test exception
  localparam logic [7:0]  FDS_CODE_EXEC    = 8'h04;  // Executing
  localparam logic [7:0]  FDS_CODE_ABORT   = 8'h05;  // Abort
  localparam logic [7:0]  FDS_CODE_CRIT    = 8'h06;  // Critical fault

  // Block state commands
  localparam logic [7:0]  FDS_CMD_RESET    = 8'h01;  // Reinitialise
  localparam logic [7:0]  FDS_CMD_ABORT    = 8'h02;  // To abort
  localparam logic [7:0]  FDS_CMD_RECOVER  = 8'h03;  // Abort to idle
  localparam logic [7:0]  FDS_CMD_EXECUTE  = 8'h04;  // To executing
  localparam logic [7:0]  FDS_CMD_STOP     = 8'h05;  // To idle
  localparam logic [7:0]  FDS_CMD_DIAG     = 8'h06;  // Restart self test

  // One-hot device states
  typedef enum logic [6:0] {
    FDS_ST_INIT    = 7'h01,
    FDS_ST_SELF    = 7'h02,
    FDS_ST_STFAULT = 7'h04,
    FDS_ST_IDLE    = 7'h08,
    FDS_ST_EXEC    = 7'h10,
    FDS_ST_ABORT   = 7'h20,
    FDS_ST_CRIT    = 7'h40
  } fds_state_t;

  // Parameter access request
  typedef struct packed {
    logic        rd;     // Read strobe
    logic        wr;     // Write strobe
    logic [7:0]  id;     // Parameter identifier
    logic [15:0] wdata;  // Write value
  } fds_req_t;

  // Parameter access answer
  typedef struct packed {
    logic        ack;    // Answer valid
    logic        err;    // Refused access
    logic [15:0] rdata;  // Read value
  } fds_rsp_t;

  // Supply and error flag events
  typedef struct packed {
    logic psu_alarm;     // Power supply alarm
    logic psu_warn;      // Power supply warning
    logic hc_alarm;      // Hot cathode supply alarm
    logic hc_warn;       // Hot cathode supply warning
    logic over_pmax;     // Pressure above maximum
    logic over_puser;    // Pressure above user limit
    logic emergency_off_key; // Emergency-off key pressed
  } fds_evt_t;

endpackage : fds_pkg

// File: logic/fds_status_block.sv
`timescale 1ns/100ps
module fds_status_block
  import fds_pkg::*;
(
  input  wire logic                     clock,             // 125 MHz clock
  input  wire logic                     resetn,            // Async reset, low
  input  wire fds_req_t                 req,               // Parameter access request
  output fds_rsp_t                      rsp,               // Parameter access answer
  input  wire logic [7:0]               common_detail0,    // Common exception detail 0
  input  wire logic                     serial_comm_alarm, // Serial link alarm level
  input  wire logic [FDS_NCH*8-1:0]     sensor_alarm,      // Per-channel alarm bytes
  input  wire logic [FDS_NCH*8-1:0]     status_ext,        // Per-channel status ext
  input  wire fds_evt_t                 evt,               // Supply and error events
  input  wire logic                     init_done,         // Controller answered
  input  wire logic                     selftest_pass,     // Self test succeeded
  input  wire logic                     selftest_fail,     // Self test found fault
  input  wire logic                     critical_fault,    // Unrecoverable fault
  input  wire logic                     cyclic_active,     // Cyclic exchange running
  output logic [7:0]                    exception_summary, // Summary for cyclic data
  output logic [15:0]                   channel_validity,  // Validity word
  output logic [7:0]                    keypad_lock,       // Current lock code
  output logic                          key_param_locked,  // Parameter keys blocked
  output logic                          key_bus_locked,    // Bus-related keys blocked
  output logic [7:0]                    device_state,      // Device state code
  output logic                          error_flag,        // Pressure/emergency flag
  output logic [3:0]                    supply_flags,      // psu_a, psu_w, hc_a, hc_w
  output logic                          supply_on_ch34,    // Pulse: restore supplies
  output logic                          clear_err_buffer   // Pulse: empty error buffer
);

  // Whole module state
  typedef struct packed {
    fds_state_t  st;         // Device state machine
    logic [7:0]  lock;       // Keypad lock code
    logic        psu_alarm;  // Sticky power supply alarm
    logic        psu_warn;   // Sticky power supply warning
    logic        hc_alarm;   // Sticky hot cathode alarm
    logic        hc_warn;    // Sticky hot cathode warning
    logic        err_flag;   // Sticky pressure/emergency flag
    logic [7:0]  summary;    // Registered summary byte
    logic [15:0] validity;   // Registered validity word
    fds_rsp_t    rsp;        // Registered answer
    logic        supply_on;  // Supply restore pulse
    logic        clr_buf;    // Buffer clear pulse
  } fds_regs_t;

  fds_regs_t r;        // Current state
  fds_regs_t next_r;   // Next state

  // State to code mapping
  function automatic logic [7:0] fds_code(input fds_state_t s);
    logic [7:0] c;
    c = FDS_CODE_INIT;
    unique case (s)
      FDS_ST_INIT:    c = FDS_CODE_INIT;
      FDS_ST_SELF:    c = FDS_CODE_SELF;
      FDS_ST_STFAULT: c = FDS_CODE_STFAULT;
      FDS_ST_IDLE:    c = FDS_CODE_IDLE;
      FDS_ST_EXEC:    c = FDS_CODE_EXEC;
      FDS_ST_ABORT:   c = FDS_CODE_ABORT;
      FDS_ST_CRIT:    c = FDS_CODE_CRIT;
      default:        c = FDS_CODE_INIT;
    endcase
    return c;
  endfunction : fds_code

  // Decoded reset command and strobes
  logic        wr_reset;     // Write to reset command
  logic        wr_lock;      // Accepted lock write
  logic        wr_cmd;       // Write of state command
  logic [7:0]  cmd;          // State command value
  logic [7:0]  rcmd;         // Reset command byte
  logic        clr_psu_a;    // Clear power supply alarm
  logic        clr_psu_w;    // Clear power supply warning
  logic        clr_hc_a;     // Clear hot cathode alarm
  logic        clr_hc_w;     // Clear hot cathode warning
  logic        clr_err;      // Clear error flag
  logic        any_sensor;   // Any channel alarm byte set
  logic        any_ext;      // Any channel status ext set
  logic        com_group;    // Device-common group flagged
  logic        mfr_group;    // Maker-specific group flagged

  // Request decode and group conditions
  always_comb begin
    rcmd      = req.wdata[7:0];
    cmd       = req.wdata[7:0];
    wr_reset  = req.wr && (req.id == FDS_ID_RESET);
    // Out-of-range lock codes are refused, not truncated
    wr_lock   = req.wr && (req.id == FDS_ID_LOCK) && (req.wdata[7:0] <= FDS_LOCK_FULL);
    wr_cmd    = req.wr && (req.id == FDS_ID_BLK_STATE);
    // Zero bits do nothing; bit 6 is never looked at
    clr_psu_a = wr_reset && (rcmd[FDS_RB_PSU_ALM] || rcmd[FDS_RB_ALL_ALM] ||
                             rcmd[FDS_RB_ALL]);
    clr_psu_w = wr_reset && (rcmd[FDS_RB_PSU_WRN] || rcmd[FDS_RB_ALL]);
    clr_hc_a  = wr_reset && (rcmd[FDS_RB_HC_ALM] || rcmd[FDS_RB_ALL_ALM] ||
                             rcmd[FDS_RB_ALL]);
    clr_hc_w  = wr_reset && (rcmd[FDS_RB_HC_WRN] || rcmd[FDS_RB_ALL]);
    clr_err   = wr_reset && (rcmd[FDS_RB_ERR_FLAG] || rcmd[FDS_RB_ALL]);
    any_sensor = 1'b0;
    any_ext    = 1'b0;
    for (int ch = 0; ch < FDS_NCH; ch++) begin
      any_sensor = any_sensor || (sensor_alarm[ch*8 +: 8] != 8'h00);
      any_ext    = any_ext || (status_ext[ch*8 +: 8] != 8'h00);
    end
    com_group = ((common_detail0 & FDS_DETAIL0_MASK) != 8'h00) || serial_comm_alarm;
    // Sticky flags are seen together with a new event of the same cycle
    mfr_group = r.psu_alarm || r.psu_warn || r.hc_alarm || r.hc_warn ||
                evt.psu_alarm || evt.psu_warn || evt.hc_alarm || evt.hc_warn;
  end

  // Next-state logic
  always_comb begin
    next_r           = r;
    next_r.supply_on = 1'b0;
    next_r.clr_buf   = 1'b0;

    // Sticky supply flags: a new event beats a clear in the same cycle
    next_r.psu_alarm = (r.psu_alarm && !clr_psu_a) || evt.psu_alarm;
    next_r.psu_warn  = (r.psu_warn && !clr_psu_w) || evt.psu_warn;
    next_r.hc_alarm  = (r.hc_alarm && !clr_hc_a) || evt.hc_alarm;
    next_r.hc_warn   = (r.hc_warn && !clr_hc_w) || evt.hc_warn;
    next_r.err_flag  = (r.err_flag && !clr_err) || evt.over_pmax ||
                       evt.over_puser || evt.emergency_off_key;
    if (wr_reset && rcmd[FDS_RB_ALL_ALM]) begin
      next_r.supply_on = 1'b1;
    end
    if (wr_reset && rcmd[FDS_RB_ALL]) begin
      next_r.clr_buf = 1'b1;
    end

    // Summary byte, rebuilt every cycle for cyclic output
    next_r.summary                = 8'h00;
    next_r.summary[FDS_SB_COM_ALM] = com_group;
    next_r.summary[FDS_SB_COM_WRN] = com_group;
    next_r.summary[FDS_SB_DEV_ALM] = any_sensor;
    next_r.summary[FDS_SB_DEV_WRN] = any_ext;
    next_r.summary[FDS_SB_MFR_ALM] = mfr_group;
    next_r.summary[FDS_SB_MFR_WRN] = mfr_group;
    next_r.summary[FDS_SB_UNUSED]  = 1'b0;
    next_r.summary[FDS_SB_EXT_FMT] = 1'b1;

    // Validity word: low three bits of each status extension byte
    for (int ch = 0; ch < FDS_NCH; ch++) begin
      next_r.validity[ch*FDS_NIB_W +: FDS_NIB_W] =
        status_ext[ch*8 +: FDS_NIB_W] & FDS_NIB_MASK;
    end

    // Keypad lock store
    if (wr_lock) begin
      next_r.lock = req.wdata[7:0];
    end

    // Device state machine
    unique case (r.st)
      FDS_ST_INIT: begin
        if (init_done) begin
          next_r.st = FDS_ST_SELF;
        end
      end
      FDS_ST_SELF: begin
        // A failure wins if both reports arrive together
        if (selftest_fail) begin
          next_r.st = FDS_ST_STFAULT;
        end else if (selftest_pass) begin
          next_r.st = FDS_ST_IDLE;
        end
      end
      FDS_ST_STFAULT: begin
        if (wr_cmd && cmd == FDS_CMD_DIAG) begin
          next_r.st = FDS_ST_SELF;
        end else if (wr_cmd && cmd == FDS_CMD_RESET) begin
          next_r.st = FDS_ST_INIT;
        end
      end
      FDS_ST_IDLE: begin
        if (wr_cmd && cmd == FDS_CMD_ABORT) begin
          next_r.st = FDS_ST_ABORT;
        end else if (wr_cmd && cmd == FDS_CMD_RESET) begin
          next_r.st = FDS_ST_INIT;
        end else if (wr_cmd && cmd == FDS_CMD_DIAG) begin
          next_r.st = FDS_ST_SELF;
        end else if (cyclic_active) begin
          next_r.st = FDS_ST_EXEC;
        end else if (wr_cmd && cmd == FDS_CMD_EXECUTE) begin
          next_r.st = FDS_ST_EXEC;
        end
      end
      FDS_ST_EXEC: begin
        if (wr_cmd && cmd == FDS_CMD_ABORT) begin
          next_r.st = FDS_ST_ABORT;
        end else if (wr_cmd && cmd == FDS_CMD_STOP) begin
          next_r.st = FDS_ST_IDLE;
        end else if (wr_cmd && cmd == FDS_CMD_RESET) begin
          next_r.st = FDS_ST_INIT;
        end else if (wr_cmd && cmd == FDS_CMD_DIAG) begin
          next_r.st = FDS_ST_SELF;
        end
      end
      FDS_ST_ABORT: begin
        if (wr_cmd && cmd == FDS_CMD_RECOVER) begin
          next_r.st = FDS_ST_IDLE;
        end else if (wr_cmd && cmd == FDS_CMD_RESET) begin
          next_r.st = FDS_ST_INIT;
        end
      end
      FDS_ST_CRIT: begin
        // Only a reinitialise leaves the fault state
        if (wr_cmd && cmd == FDS_CMD_RESET) begin
          next_r.st = FDS_ST_INIT;
        end
      end
      default: begin
        next_r.st = FDS_ST_INIT;
      end
    endcase
    // Any normal state falls into critical fault
    if (critical_fault && r.st != FDS_ST_CRIT) begin
      next_r.st = FDS_ST_CRIT;
    end

    // Parameter answer, one cycle after the strobe
    next_r.rsp.ack   = req.rd || req.wr;
    next_r.rsp.err   = 1'b0;
    next_r.rsp.rdata = 16'h0000;
    if (req.rd) begin
      unique case (req.id)
        FDS_ID_SUMMARY:   next_r.rsp.rdata = {8'h00, r.summary};
        FDS_ID_LOCK:      next_r.rsp.rdata = {8'h00, r.lock};
        FDS_ID_VALIDITY:  next_r.rsp.rdata = r.validity;
        FDS_ID_DEV_STATE: next_r.rsp.rdata = {8'h00, fds_code(r.st)};
        FDS_ID_BLK_STATE: next_r.rsp.rdata = {8'h00, fds_code(r.st)};
        // Write-only and unknown identifiers are refused
        default:          next_r.rsp.err   = 1'b1;
      endcase
    end else if (req.wr) begin
      unique case (req.id)
        FDS_ID_RESET:     next_r.rsp.err = 1'b0;
        FDS_ID_BLK_STATE: next_r.rsp.err = 1'b0;
        FDS_ID_LOCK:      next_r.rsp.err = !wr_lock;
        // Read-only and unknown identifiers are refused
        default:          next_r.rsp.err = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r.st        <= FDS_ST_INIT;
      r.lock      <= FDS_LOCK_OFF;
      r.psu_alarm <= 1'b0;
      r.psu_warn  <= 1'b0;
      r.hc_alarm  <= 1'b0;
      r.hc_warn   <= 1'b0;
      r.err_flag  <= 1'b0;
      r.summary   <= 8'h80;
      r.validity  <= 16'h0000;
      r.rsp       <= '0;
      r.supply_on <= 1'b0;
      r.clr_buf   <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // Outputs from flip-flops; key locks and state code are decoded from them
  assign rsp               = r.rsp;
  assign exception_summary = r.summary;
  assign channel_validity  = r.validity;
  assign keypad_lock       = r.lock;
  assign key_param_locked  = (r.lock == FDS_LOCK_PARA) || (r.lock == FDS_LOCK_FULL);
  assign key_bus_locked    = (r.lock == FDS_LOCK_BUS) || (r.lock == FDS_LOCK_FULL);
  assign device_state      = fds_code(r.st);
  assign error_flag        = r.err_flag;
  assign supply_flags      = {r.psu_alarm, r.psu_warn, r.hc_alarm, r.hc_warn};
  assign supply_on_ch34    = r.supply_on;
  assign clear_err_buffer  = r.clr_buf;

endmodule : fds_status_block

// File: tb/fds_status_chk.sv
`timescale 1ns/100ps
module fds_status_chk
  import fds_pkg::*;
(
  input wire logic              clock,             // Clock
  input wire logic              resetn,            // Async reset, low
  input wire fds_req_t          req,               // Access request
  input wire fds_rsp_t          rsp,               // Access answer
  input wire logic [7:0]        common_detail0,    // Detail 0
  input wire logic              serial_comm_alarm, // Serial alarm
  input wire logic [31:0]       sensor_alarm,      // Alarm bytes
  input wire logic [31:0]       status_ext,        // Status ext bytes
  input wire fds_evt_t          evt,               // Events
  input wire logic              init_done,         // Init answered
  input wire logic              selftest_pass,     // Test ok
  input wire logic              selftest_fail,     // Test fault
  input wire logic              critical_fault,    // Fatal fault
  input wire logic              cyclic_active,     // Cyclic running
  input wire logic [7:0]        exception_summary, // Summary
  input wire logic [15:0]       channel_validity,  // Validity
  input wire logic [7:0]        keypad_lock,       // Lock code
  input wire logic              key_param_locked,  // Param keys off
  input wire logic              key_bus_locked,    // Bus keys off
  input wire logic [7:0]        device_state,      // State code
  input wire logic              error_flag,        // Error flag
  input wire logic [3:0]        supply_flags,      // Supply flags
  input wire logic              supply_on_ch34,    // Supply pulse
  input wire logic              clear_err_buffer   // Buffer pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Helper terms, kept as signals so $past sees plain names
  logic        rst_wr;   // Reset command write taken
  logic        com_c;    // Common group cause
  logic        buf_c;    // Bit 7 command
  logic        sup_c;    // Bit 4 command
  logic        any_sup;  // Any supply flag
  logic [15:0] nib_c;    // Expected validity
  assign rst_wr = req.wr && (req.id == FDS_ID_RESET);
  assign com_c = (|(common_detail0 & FDS_DETAIL0_MASK)) || serial_comm_alarm;
  assign buf_c = rst_wr && req.wdata[7];
  assign sup_c = rst_wr && req.wdata[4];
  assign any_sup = |supply_flags;
  assign nib_c = {1'b0, status_ext[26:24], 1'b0, status_ext[18:16],
                  1'b0, status_ext[10:8], 1'b0, status_ext[2:0]};
  // Boot steps
  sequence s_init;
    device_state == FDS_CODE_INIT && init_done && !critical_fault;
  endsequence
  sequence s_pass;
    device_state == FDS_CODE_SELF && selftest_pass && !selftest_fail && !critical_fault;
  endsequence
  fmt_bits_a: assert property (exception_summary[7] && !exception_summary[3])
    else $error("summary fixed bits wrong");
  common_grp_a: assert property ($past(resetn) |-> exception_summary[0] == $past(com_c)
    && exception_summary[4] == $past(com_c)) else $error("common group bits wrong");
  dev_alarm_a: assert property ($past(resetn) |-> exception_summary[1] ==
    |$past(sensor_alarm)) else $error("device alarm bit wrong");
  dev_warn_a: assert property ($past(resetn) |-> exception_summary[5] == |$past(status_ext))
    else $error("device warning bit wrong");
  validity_map_a: assert property ($past(resetn) |-> channel_validity == $past(nib_c))
    else $error("validity word wrong");
  param_ack_a: assert property ((req.rd || req.wr) |=> rsp.ack)
    else $error("access not answered");
  lock_decode_a: assert property (key_param_locked == (keypad_lock == 8'h01 ||
    keypad_lock == 8'h03) && key_bus_locked == (keypad_lock == 8'h02 ||
    keypad_lock == 8'h03)) else $error("lock wrong");
  buffer_clear_a: assert property ($past(resetn) |-> clear_err_buffer == $past(buf_c))
    else $error("buffer clear pulse wrong");
  supply_on_a: assert property ($past(resetn) |-> supply_on_ch34 == $past(sup_c))
    else $error("supply restore pulse wrong");
  err_clear_a: assert property (rst_wr && req.wdata[5] && !evt.over_pmax && !evt.over_puser
    && !evt.emergency_off_key |=> !error_flag) else $error("error flag not cleared");
  supply_sum_a: assert property ($rose(any_sup) |-> exception_summary[2] &&
    exception_summary[6]) else $error("supply group bits wrong");
  boot_init_a: assert property (s_init |=> device_state == FDS_CODE_SELF)
    else $error("init step wrong");
  boot_pass_a: assert property (s_pass |=> device_state == FDS_CODE_IDLE)
    else $error("self test step wrong");
  cyclic_exec_a: assert property (device_state == FDS_CODE_IDLE && cyclic_active && !req.wr
    && !critical_fault |=> device_state == FDS_CODE_EXEC) else $error("cyclic start wrong");
endmodule : fds_status_chk

bind fds_status_block fds_status_chk chk_i (.clock(clock), .resetn(resetn), .req(req),
  .rsp(rsp), .common_detail0(common_detail0), .serial_comm_alarm(serial_comm_alarm),
  .sensor_alarm(sensor_alarm), .status_ext(status_ext), .evt(evt), .init_done(init_done),
  .selftest_pass(selftest_pass), .selftest_fail(selftest_fail),
  .critical_fault(critical_fault), .cyclic_active(cyclic_active),
  .exception_summary(exception_summary), .channel_validity(channel_validity),
  .keypad_lock(keypad_lock), .key_param_locked(key_param_locked),
  .key_bus_locked(key_bus_locked), .device_state(device_state), .error_flag(error_flag),
  .supply_flags(supply_flags), .supply_on_ch34(supply_on_ch34),
  .clear_err_buffer(clear_err_buffer));

// File: tb/fds_master_model.sv
`timescale 1ns/100ps
module fds_master_model
  import fds_pkg::*;
(
  input  wire logic     clock, // Clock
  input  wire fds_rsp_t rsp,   // Device answer
  output fds_req_t      req    // Request to device
);
  initial req = '0;
  // One strobe cycle, then released lines show the inverse so no stale id lingers
  task automatic access(input logic r, input logic w, input logic [7:0] a,
                        input logic [15:0] d, output fds_rsp_t ans);
    @(posedge clock);
    req <= '{rd: r, wr: w, id: a, wdata: d};
    @(posedge clock);
    req <= '{rd: 1'b0, wr: 1'b0, id: ~a, wdata: ~d};
    ans = '0;
    // Answer stands one cycle only, so look at every edge
    repeat (3) begin
      @(posedge clock);
      if (rsp.ack === 1'b1) begin
        ans = rsp;
        break;
      end
    end
  endtask : access
endmodule : fds_master_model

// File: tb/fds_status_block_tb_top.sv
`timescale 1ns/100ps
module fds_status_block_tb_top
  import fds_pkg::*;
;
  logic        clock, resetn, ser, ini, pass, fail, crit, cyc; // Stimulus
  logic [7:0]  det0, summ, lock, dst;                          // Bytes
  logic [31:0] sa, se;                                         // Channel bytes
  logic [15:0] valid;                                          // Validity
  logic        kp, kb, eflag, son, cbuf;                       // Flags
  logic [3:0]  sflags;                                         // Supply flags
  fds_evt_t    evt;                                            // Events
  fds_req_t    req;                                            // Request
  fds_rsp_t    rsp;                                            // Answer
  int          fail_count, check_count, cycles;                // Counters
  logic [7:0]  cmd_tab [5] = '{8'h04, 8'h05, 8'h02, 8'h03, 8'h06}; // Commands
  logic [7:0]  exp_tab [5] = '{8'h04, 8'h02, 8'h05, 8'h02, 8'h01}; // States
  fds_status_block dut (.clock(clock), .resetn(resetn), .req(req), .rsp(rsp),
    .common_detail0(det0), .serial_comm_alarm(ser), .sensor_alarm(sa), .status_ext(se),
    .evt(evt), .init_done(ini), .selftest_pass(pass), .selftest_fail(fail),
    .critical_fault(crit), .cyclic_active(cyc), .exception_summary(summ),
    .channel_validity(valid), .keypad_lock(lock), .key_param_locked(kp),
    .key_bus_locked(kb), .device_state(dst), .error_flag(eflag), .supply_flags(sflags),
    .supply_on_ch34(son), .clear_err_buffer(cbuf));
  fds_master_model m (.clock(clock), .rsp(rsp), .req(req));
  // 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // Hang guard, far above the 180 or so cycles needed
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fail_count++;
      conclude();
    end
  end
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task rd(input logic [7:0] a, input logic [15:0] exp, input logic e);
    fds_rsp_t r;
    m.access(1'b1, 1'b0, a, 16'h0000, r);
    chk("read answer", {14'h0, r.ack, r.err}, {14'h0, 1'b1, e});
    chk("read data", r.rdata, exp);
  endtask : rd
  task wr(input logic [7:0] a, input logic [15:0] d, input logic e);
    fds_rsp_t r;
    m.access(1'b0, 1'b1, a, d, r);
    chk("write answer", {14'h0, r.ack, r.err}, {14'h0, 1'b1, e});
  endtask : wr
  task sum_case(input logic [7:0] d, input logic s, input logic [31:0] a,
                input logic [31:0] x, input logic [7:0] exp);
    @(posedge clock);
    det0 <= d;
    ser <= s;
    sa <= a;
    se <= x;
    repeat (2) @(posedge clock);
    rd(FDS_ID_SUMMARY, {8'h00, exp}, 1'b0);
  endtask : sum_case
  task pulse(input fds_evt_t v);
    @(posedge clock);
    evt <= v;
    @(posedge clock);
    evt <= '0;
    @(posedge clock);
  endtask : pulse
  task rcmd(input logic [15:0] d, input logic [3:0] exp);
    wr(FDS_ID_RESET, d, 1'b0);
    chk("supply flags", {12'h000, sflags}, {12'h000, exp});
  endtask : rcmd
  // Main sequence
  initial begin
    {resetn, ser, ini, pass, fail, crit, cyc} = '0;
    {det0, sa, se, evt} = '0;
    repeat (2) @(posedge clock);
    chk("summary in reset", {8'h00, summ}, 16'h0080);
    chk("state in reset", {8'h00, dst}, 16'h0064);
    resetn <= 1'b1;
    ini <= 1'b1;
    repeat (2) @(posedge clock);
    chk("self test state", {8'h00, dst}, 16'h0001);
    pass <= 1'b1;
    repeat (2) @(posedge clock);
    rd(FDS_ID_DEV_STATE, 16'h0002, 1'b0);
    $display("test boot done");
    sum_case(8'h02, 1'b0, 32'h0, 32'h0, 8'h80);
    sum_case(8'h20, 1'b0, 32'h0, 32'h0, 8'h91);
    sum_case(8'h00, 1'b1, 32'h0, 32'h0, 8'h91);
    sum_case(8'h00, 1'b0, 32'h01000000, 32'h0, 8'h82);
    sum_case(8'h00, 1'b0, 32'h0, 32'h00000800, 8'hA0);
    chk("reserved nibble bit", valid, 16'h0000);
    sum_case(8'h00, 1'b0, 32'h0, 32'h0F06F901, 8'hA0);
    rd(FDS_ID_VALIDITY, 16'h7611, 1'b0);
    se <= 32'h0;
    $display("test summary done");
    for (int i = 0; i < 4; i++) begin
      wr(FDS_ID_LOCK, i[15:0], 1'b0);
      rd(FDS_ID_LOCK, i[15:0], 1'b0);
      chk("key locks", {14'h0, kb, kp}, i[15:0]);
    end
    wr(FDS_ID_LOCK, 16'h0004, 1'b1);
    rd(FDS_ID_LOCK, 16'h0003, 1'b0);
    rd(FDS_ID_RESET, 16'h0000, 1'b1);
    wr(FDS_ID_SUMMARY, 16'h00FF, 1'b1);
    rd(8'h55, 16'h0000, 1'b1);
    $display("test lock done");
    for (int i = 0; i < 4; i++) begin
      pulse(7'h78);
      chk("supply group bits", {8'h00, summ & 8'h44}, 16'h0044);
      rcmd(16'h0001 << i, 4'hF ^ (4'h8 >> i));
    end
    rcmd(16'h0000, 4'hE);
    rcmd(16'h0040, 4'hE);
    rcmd(16'h0010, 4'h4);
    rcmd(16'h0080, 4'h0);
    @(posedge clock);
    chk("summary clear", {8'h00, summ}, 16'h0080);
    for (int i = 0; i < 3; i++) begin
      pulse(7'h04 >> i);
      chk("error flag set", {15'h0, eflag}, 16'h0001);
      rcmd(16'h0020, 4'h0);
      chk("error flag clear", {15'h0, eflag}, 16'h0000);
    end
    $display("test reset command done");
    pass <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wr(FDS_ID_BLK_STATE, {8'h00, cmd_tab[i]}, 1'b0);
      @(posedge clock);
      chk("commanded state", {8'h00, dst}, {8'h00, exp_tab[i]});
    end
    wr(FDS_ID_BLK_STATE, 16'h0003, 1'b0);
    fail <= 1'b1;
    repeat (2) @(posedge clock);
    chk("self test fault", {8'h00, dst}, 16'h0003);
    fail <= 1'b0;
    pass <= 1'b1;
    wr(FDS_ID_BLK_STATE, 16'h0006, 1'b0);
    repeat (3) @(posedge clock);
    cyc <= 1'b1;
    repeat (2) @(posedge clock);
    chk("cyclic start", {8'h00, dst}, 16'h0004);
    crit <= 1'b1;
    repeat (2) @(posedge clock);
    chk("critical state", {8'h00, dst}, 16'h0006);
    $display("test state done");
    conclude();
  end
endmodule : fds_status_block_tb_top
